//--- usb_root_hub_status_regs.sv
`default_nettype none
// Operation
// - writing 1 to hub bit 31 clears the wake enable flag
// - overcurrent change bit 17 sets on indicator change, write 1 clears
// - hub bits 16 and 0 always read as zero
// - global scheme: write 1 to hub bit 16 powers all ports
// - per-port scheme: power-on write affects only unmasked ports
// - global scheme: write 1 to hub bit 0 powers all ports off
// - per-port scheme: power-off write affects only unmasked ports
// - wake enabled: connect change resumes from suspend, raises interrupt
// - writing 1 to hub bit 15 sets the wake enable flag
// - hub bit 1 shows global overcurrent, zero under per-port reporting
// - port one at code 15h/95h, port two at 16h/96h
// - one per-port register for each downstream port
// - per-port register: status low half, change flags high half
// - port writes during a busy transaction wait until it finishes
// - change flags at bits 20 to 16, all reset to zero
// - hub level register at code 14h/94h
module usb_root_hub_status_regs
  import usb_root_hub_pkg::*;
#(
  parameter int PORT_COUNT = 2,
  parameter int ADDR_W     = 12
) (
  // clock and reset
  input  wire  logic                    clk,
  input  wire  logic                    rst,
  // apb slave
  input  wire  logic                    psel,
  input  wire  logic                    penable,
  input  wire  logic                    pwrite,
  input  wire  logic [ADDR_W-1:0]       paddr,
  input  wire  logic [31:0]             pwdata,
  output var   logic [31:0]             prdata,
  output logic                          pready,
  output logic                          pslverr,
  // pins
  input  wire  logic                    overcurrentPin,
  input  wire  logic [PORT_COUNT-1:0]   connectPin,
  // port engine
  input  wire  logic [PORT_COUNT-1:0]   portBusy,
  input  wire  port_event_t [PORT_COUNT-1:0] portEvent,
  output var   logic [PORT_COUNT-1:0]   portPowerState,
  // controller state and interrupt
  output var   hc_state_t               controllerState,
  output logic                          irq
);

  localparam int IRQ_W = IRQ_CONNECT_LSB + PORT_COUNT;

  // apb phase and address decode
  logic                  setupPhase;
  logic                  accessPhase;
  logic [7:0]            regIndex;
  logic                  aligned;
  logic                  hubHit;
  logic                  cfgHit;
  logic                  irqStatHit;
  logic                  irqMaskHit;
  logic                  ctlHit;
  logic [PORT_COUNT-1:0] portHit;
  logic                  mapped;
  logic                  wrEn;
  logic                  rdEn;

  assign setupPhase  = psel & ~penable;
  assign accessPhase = psel & penable;
  assign regIndex    = paddr[9:2];
  assign aligned     = (paddr[1:0] == 2'h0) &&
                       (paddr[ADDR_W-1:10] == '0);
  assign hubHit      = regIndex == HUB_INDEX;
  assign cfgHit      = regIndex == CONFIG_INDEX;
  assign irqStatHit  = regIndex == IRQ_STATUS_INDEX;
  assign irqMaskHit  = regIndex == IRQ_MASK_INDEX;
  assign ctlHit      = regIndex == CONTROL_INDEX;
  assign mapped      = aligned & (hubHit | cfgHit | irqStatHit |
                       irqMaskHit | ctlHit | (|portHit));
  assign wrEn        = accessPhase & pwrite & mapped;
  assign rdEn        = accessPhase & ~pwrite & mapped;

  // zero wait answer, error on unmapped address
  assign pready  = accessPhase;
  assign pslverr = accessPhase & ~mapped;

  // configuration and control registers
  logic                  powerScheme;
  logic                  ocPerPort;
  logic [PORT_COUNT-1:0] portPowerMask;
  logic [IRQ_W-1:0]      irqMask;
  logic [IRQ_W-1:0]      irqStatus;
  logic [IRQ_W-1:0]      irqEvents;

  always_ff @(posedge clk) begin
    if (rst) begin
      powerScheme   <= 1'b0;
      ocPerPort     <= 1'b0;
      portPowerMask <= '0;
    end else if (wrEn & cfgHit) begin
      powerScheme   <= pwdata[CFG_SCHEME_BIT];
      ocPerPort     <= pwdata[CFG_OC_PORT_BIT];
      portPowerMask <= pwdata[CFG_MASK_LSB +: PORT_COUNT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irqMask <= '0;
    end else if (wrEn & irqMaskHit) begin
      irqMask <= pwdata[IRQ_W-1:0];
    end
  end

  // overcurrent pin synchroniser and change detect
  logic ocSync1;
  logic ocSync2;
  logic ocGlobal;
  logic ocGlobalLast;
  logic ocChangeEvt;

  always_ff @(posedge clk) begin
    if (rst) begin
      ocSync1      <= 1'b0;
      ocSync2      <= 1'b0;
      ocGlobalLast <= 1'b0;
    end else begin
      ocSync1      <= overcurrentPin;
      ocSync2      <= ocSync1;
      ocGlobalLast <= ocGlobal;
    end
  end

  assign ocGlobal    = ocSync2 & ~ocPerPort;
  assign ocChangeEvt = ocGlobal ^ ocGlobalLast;

  // hub level flags
  logic wakeEnableFlag;
  logic overcurrentChangeFlag;
  logic hubWrite;
  logic powerOnAll;
  logic powerOffAll;

  assign hubWrite    = wrEn & hubHit;
  assign powerOnAll  = hubWrite & pwdata[HUB_POWER_ON_BIT];
  assign powerOffAll = hubWrite & pwdata[HUB_POWER_OFF_BIT];

  // wake enable: set and clear commands, set wins if both
  always_ff @(posedge clk) begin
    if (rst) begin
      wakeEnableFlag <= 1'b0;
    end else if (hubWrite & pwdata[HUB_WAKE_BIT]) begin
      wakeEnableFlag <= 1'b1;
    end else if (hubWrite & pwdata[HUB_WAKE_CLEAR_BIT]) begin
      wakeEnableFlag <= 1'b0;
    end
  end

  // overcurrent change flag, hardware set beats software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      overcurrentChangeFlag <= 1'b0;
    end else begin
      overcurrentChangeFlag <= ocChangeEvt |
        (overcurrentChangeFlag &
         ~(hubWrite & pwdata[HUB_OC_CHANGE_BIT]));
    end
  end

  // per-port registers
  logic [PORT_COUNT-1:0] connectEdge;
  logic [31:0]           portWord [PORT_COUNT];

  genvar p;
  generate
    for (p = 0; p < PORT_COUNT; p++) begin : g_port
      logic                     connSync1;
      logic                     connSync2;
      logic                     connLast;
      logic                     pendValid;
      logic [31:0]              pendData;
      logic                     portWrite;
      logic                     applyNow;
      logic [31:0]              applyData;
      logic [PORT_CHANGE_W-1:0] changeFlags;
      logic [PORT_CHANGE_W-1:0] changeSet;
      logic [PORT_CHANGE_W-1:0] changeClr;
      logic                     globalAffects;

      // port p answers at index PORT1_INDEX + p
      assign portHit[p] = regIndex == 8'(int'(PORT1_INDEX) + p);
      assign portWrite  = wrEn & portHit[p];

      // connect pin synchroniser
      always_ff @(posedge clk) begin
        if (rst) begin
          connSync1 <= 1'b0;
          connSync2 <= 1'b0;
          connLast  <= 1'b0;
        end else begin
          connSync1 <= connectPin[p];
          connSync2 <= connSync1;
          connLast  <= connSync2;
        end
      end

      assign connectEdge[p] = connSync2 ^ connLast;

      // hold writes that land during a transaction
      always_ff @(posedge clk) begin
        if (rst) begin
          pendValid <= 1'b0;
          pendData  <= ZERO_WORD;
        end else if (portWrite & portBusy[p]) begin
          pendValid <= 1'b1;
          pendData  <= pendData | pwdata;
        end else if (applyNow) begin
          pendValid <= 1'b0;
          pendData  <= ZERO_WORD;
        end
      end

      assign applyNow  = ~portBusy[p] & (pendValid | portWrite);
      assign applyData = (pendValid ? pendData : ZERO_WORD) |
                         (portWrite ? pwdata : ZERO_WORD);

      // change flag sources and write-one clears
      assign changeSet[CHG_CONNECT] = connectEdge[p];
      assign changeSet[CHG_ENABLE]  = portEvent[p].enableChange;
      assign changeSet[CHG_RESUME]  = portEvent[p].resumeDone;
      assign changeSet[CHG_OC]      = portEvent[p].ocChange & ocPerPort;
      assign changeSet[CHG_RESET]   = portEvent[p].resetDone;
      assign changeClr = applyNow ?
        applyData[PORT_CHANGE_LSB +: PORT_CHANGE_W] : '0;

      // resume flag also drops when reset completes; sets win
      always_ff @(posedge clk) begin
        if (rst) begin
          changeFlags <= '0;
        end else begin
          changeFlags <= changeSet | (changeFlags & ~changeClr);
          if (changeSet[CHG_RESET] & ~changeSet[CHG_RESUME]) begin
            changeFlags[CHG_RESUME] <= 1'b0;
          end
        end
      end

      // port power: global commands honour scheme and mask
      assign globalAffects = ~powerScheme | ~portPowerMask[p];

      always_ff @(posedge clk) begin
        if (rst) begin
          portPowerState[p] <= 1'b0;
        end else if (powerOffAll & globalAffects) begin
          portPowerState[p] <= 1'b0;
        end else if (powerOnAll & globalAffects) begin
          portPowerState[p] <= 1'b1;
        end else if (applyNow & applyData[PORT_CLR_POWER_BIT]) begin
          portPowerState[p] <= 1'b0;
        end else if (applyNow & applyData[PORT_SET_POWER_BIT]) begin
          portPowerState[p] <= 1'b1;
        end
      end

      // status low half, change flags high half
      always_comb begin
        portWord[p]                   = ZERO_WORD;
        portWord[p][PORT_CONNECT_BIT] = connSync2;
        portWord[p][PORT_POWER_BIT]   = portPowerState[p];
        portWord[p][PORT_CHANGE_LSB +: PORT_CHANGE_W] = changeFlags;
      end
    end
  endgenerate

  // suspend and resume sequencing
  logic resumeEvt;

  assign resumeEvt = wakeEnableFlag & (|connectEdge) &
                     (controllerState == SUSPENDED_STATE);

  always_ff @(posedge clk) begin
    if (rst) begin
      controllerState <= OPERATIONAL;
    end else begin
      case (controllerState)
        OPERATIONAL: begin
          if (wrEn & ctlHit & pwdata[CTL_SUSPEND_BIT]) begin
            controllerState <= SUSPENDED_STATE;
          end
        end
        SUSPENDED_STATE: begin
          if (resumeEvt) begin
            controllerState <= RESUMING_STATE;
          end
        end
        RESUMING_STATE: begin
          if (wrEn & ctlHit & pwdata[CTL_RESUMED_BIT]) begin
            controllerState <= OPERATIONAL;
          end
        end
        default: controllerState <= OPERATIONAL;
      endcase
    end
  end

  // sticky interrupt status; a read clears only the bits it returned
  assign irqEvents[IRQ_OC_BIT]     = ocChangeEvt;
  assign irqEvents[IRQ_RESUME_BIT] = resumeEvt;
  assign irqEvents[IRQ_CONNECT_LSB +: PORT_COUNT] = connectEdge;

  always_ff @(posedge clk) begin
    if (rst) begin
      irqStatus <= '0;
    end else if (rdEn & irqStatHit) begin
      // events of the setup cycle were not in prdata, so they stay
      irqStatus <= (irqStatus & ~prdata[IRQ_W-1:0]) | irqEvents;
    end else begin
      irqStatus <= irqStatus | irqEvents;
    end
  end

  assign irq = |(irqStatus & irqMask);

  // read words
  logic [31:0] hubWord;
  logic [31:0] cfgWord;
  logic [31:0] ctlWord;
  logic [31:0] readWord;

  // power bits 16 and 0 read as zero
  always_comb begin
    hubWord                    = ZERO_WORD;
    hubWord[HUB_OC_CHANGE_BIT] = overcurrentChangeFlag;
    hubWord[HUB_WAKE_BIT]      = wakeEnableFlag;
    hubWord[HUB_OC_BIT]        = ocGlobal;
  end

  always_comb begin
    cfgWord                  = ZERO_WORD;
    cfgWord[CFG_SCHEME_BIT]  = powerScheme;
    cfgWord[CFG_OC_PORT_BIT] = ocPerPort;
    cfgWord[CFG_MASK_LSB +: PORT_COUNT] = portPowerMask;
  end

  always_comb begin
    ctlWord = ZERO_WORD;
    ctlWord[CTL_STATE_W-1:0] = controllerState;
  end

  // read selection, ports folded in by index
  always_comb begin
    readWord = ZERO_WORD;
    if (hubHit) readWord = hubWord;
    if (cfgHit) readWord = cfgWord;
    if (ctlHit) readWord = ctlWord;
    if (irqStatHit) readWord = 32'(irqStatus);
    if (irqMaskHit) readWord = 32'(irqMask);
    for (int i = 0; i < PORT_COUNT; i++) begin
      if (portHit[i]) readWord = portWord[i];
    end
    if (!aligned) readWord = ZERO_WORD;
  end

  // read data captured in the setup cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= ZERO_WORD;
    end else if (setupPhase & ~pwrite) begin
      prdata <= readWord;
    end
  end

endmodule
`default_nettype wire

//--- usb_root_hub_pkg.sv
`default_nettype none
package usb_root_hub_pkg;

  // register indices; the apb byte address is four times the index
  localparam logic [7:0] HUB_INDEX        = 8'h14;
  localparam logic [7:0] PORT1_INDEX      = 8'h15;
  localparam logic [7:0] PORT2_INDEX      = 8'h16;
  localparam logic [7:0] CONFIG_INDEX     = 8'h18;
  localparam logic [7:0] IRQ_STATUS_INDEX = 8'h19;
  localparam logic [7:0] IRQ_MASK_INDEX   = 8'h1A;
  localparam logic [7:0] CONTROL_INDEX    = 8'h1B;
  // command code of a write is the read code with this bit added
  localparam logic [7:0] WRITE_CODE_FLAG  = 8'h80;

  localparam int        DATA_W    = 32;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // hub level word
  localparam int HUB_WAKE_CLEAR_BIT = 31;
  localparam int HUB_OC_CHANGE_BIT  = 17;
  localparam int HUB_POWER_ON_BIT   = 16;
  localparam int HUB_WAKE_BIT       = 15;
  localparam int HUB_OC_BIT         = 1;
  localparam int HUB_POWER_OFF_BIT  = 0;

  // per port word, status half
  localparam int PORT_CONNECT_BIT   = 0;
  localparam int PORT_POWER_BIT     = 8;
  localparam int PORT_SET_POWER_BIT = 8;
  localparam int PORT_CLR_POWER_BIT = 9;
  // per port word, change half
  localparam int PORT_CHANGE_LSB    = 16;
  localparam int PORT_CHANGE_W      = 5;
  localparam int CHG_CONNECT        = 0;
  localparam int CHG_ENABLE         = 1;
  localparam int CHG_RESUME         = 2;
  localparam int CHG_OC             = 3;
  localparam int CHG_RESET          = 4;

  // configuration word
  localparam int CFG_SCHEME_BIT     = 0;
  localparam int CFG_OC_PORT_BIT    = 1;
  localparam int CFG_MASK_LSB       = 17;

  // control word
  localparam int CTL_SUSPEND_BIT    = 0;
  localparam int CTL_RESUMED_BIT    = 1;
  localparam int CTL_STATE_W        = 2;

  // interrupt status and mask layout
  localparam int IRQ_OC_BIT         = 0;
  localparam int IRQ_RESUME_BIT     = 1;
  localparam int IRQ_CONNECT_LSB    = 2;

  typedef enum logic [1:0] {
    OPERATIONAL,
    SUSPENDED_STATE,
    RESUMING_STATE
  } hc_state_t;

  // hardware events reported by the port logic, one-cycle pulses
  typedef struct packed {
    logic resetDone;
    logic ocChange;
    logic resumeDone;
    logic enableChange;
  } port_event_t;

endpackage
`default_nettype wire

//--- usb_root_hub_status_regs_sva.sv
`default_nettype none
module usb_root_hub_status_regs_sva
  import usb_root_hub_pkg::*;
#(
  parameter int PORT_COUNT = 2,
  parameter int ADDR_W     = 12
) (
  // observed ports
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [ADDR_W-1:0]         paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire logic                      overcurrentPin,
  input wire logic [PORT_COUNT-1:0]     connectPin,
  input wire logic [PORT_COUNT-1:0]     portBusy,
  input wire port_event_t [PORT_COUNT-1:0] portEvent,
  input wire logic [PORT_COUNT-1:0]     portPowerState,
  input wire hc_state_t                 controllerState,
  input wire logic                      irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // access decode, shadow of config word and wake flag
  wire logic       acc = psel && penable;
  wire logic [7:0] idx = paddr[9:2];
  wire logic       wrH = acc && pwrite && idx == HUB_INDEX;
  wire logic       wrC = acc && pwrite && idx == CONFIG_INDEX;
  logic [31:0]     cfg;
  logic            wake;
  wire logic [PORT_COUNT-1:0] aff =
    cfg[CFG_SCHEME_BIT] ? ~cfg[CFG_MASK_LSB +: PORT_COUNT] : '1;
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg  <= '0;
      wake <= 1'b0;
    end else begin
      if (wrC) cfg <= pwdata;
      if (wrH && pwdata[HUB_WAKE_BIT]) wake <= 1'b1;
      else if (wrH && pwdata[HUB_WAKE_CLEAR_BIT]) wake <= 1'b0;
    end
  end
  // read setups of the hub word and a port word
  sequence s_hub_rd;
    psel && !penable && !pwrite && idx == HUB_INDEX;
  endsequence
  sequence s_port_rd;
    psel && !penable && !pwrite && idx == PORT1_INDEX;
  endsequence
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_mapped_no_err: assert property (acc && (idx == HUB_INDEX ||
    idx == PORT1_INDEX || idx == PORT2_INDEX) |-> pready && !pslverr)
    else $error("mapped register refused");
  a_no_third_port: assert property (acc && idx == 8'h17 |-> pslverr)
    else $error("third port word answered");
  a_low_power_zero: assert property (s_hub_rd |=> !prdata[16] && !prdata[0])
    else $error("hub power bits not zero");
  a_oc_per_port: assert property (s_hub_rd ##0 cfg[1] |=> !prdata[1])
    else $error("hub overcurrent bit set in per-port mode");
  a_wake_readback: assert property (s_hub_rd |=> prdata[15] == wake)
    else $error("wake flag readback wrong");
  a_global_on: assert property (wrH && pwdata[16] && !pwdata[0] |=>
    portPowerState == ($past(portPowerState) | $past(aff)))
    else $error("global power on wrong");
  a_global_off: assert property (wrH && pwdata[0] |=>
    portPowerState == ($past(portPowerState) & ~$past(aff)))
    else $error("global power off wrong");
  a_busy_holds: assert property (acc && pwrite && idx == PORT1_INDEX
    && portBusy[0] |=> $stable(portPowerState))
    else $error("port write applied during transaction");
  a_resume_wake: assert property (controllerState == RESUMING_STATE &&
    $past(controllerState) == SUSPENDED_STATE |-> $past(wake))
    else $error("resume without wake enable");
  a_port_reserved: assert property (s_port_rd |=> prdata[31:21] == 11'h000)
    else $error("port word reserved bits set");
endmodule
bind usb_root_hub_status_regs usb_root_hub_status_regs_sva #(
  .PORT_COUNT(PORT_COUNT), .ADDR_W(ADDR_W)
) usb_root_hub_status_regs_sva_i (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .overcurrentPin(overcurrentPin),
  .connectPin(connectPin), .portBusy(portBusy), .portEvent(portEvent),
  .portPowerState(portPowerState), .controllerState(controllerState),
  .irq(irq)
);
`default_nettype wire

//--- host_apb_model.sv
`default_nettype none
module host_apb_model #(
  parameter int ADDR_W = 12
) (
  // clock
  input  wire logic              clk,
  // apb master
  output var  logic              psel,
  output var  logic              penable,
  output var  logic              pwrite,
  output var  logic [ADDR_W-1:0] paddr,
  output var  logic [31:0]       pwdata,
  input  wire logic [31:0]       prdata,
  input  wire logic              pready,
  input  wire logic              pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] rdLast;
  logic        errLast;
  logic        toLast;
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
  end
  // setup, then access held until pready at an edge; no local limit
  task automatic xfer(input logic wr, input logic [7:0] index,
                      input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ADDR_W'({index, 2'b00});
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rdLast  = prdata;
    errLast = pslverr;
    // flags any wait state; the slave should answer at once
    toLast  = (n != 1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // released bus shows no stale values
    paddr   <= ~paddr;
    pwdata  <= ~pwdata;
  endtask
endmodule
`default_nettype wire

//--- usb_root_hub_status_regs_tb_top.sv
`default_nettype none
module usb_root_hub_status_regs_tb_top;
  import usb_root_hub_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata;
  logic             overcurrentPin = 1'b0;
  logic [1:0]       connectPin = 2'b00;
  logic [1:0]       portBusy = 2'b00;
  port_event_t [1:0] portEvent = '0;
  logic [1:0]       portPowerState;
  hc_state_t        controllerState;
  logic [31:0]      seed = 32'h0001_2D49;
  int               badCount = 0;
  int               nTests = 0;
  always #20 clk = ~clk;
  usb_root_hub_status_regs usb_root_hub_status_regs_i (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .overcurrentPin(overcurrentPin), .connectPin(connectPin),
    .portBusy(portBusy), .portEvent(portEvent),
    .portPowerState(portPowerState), .controllerState(controllerState),
    .irq(irq));
  host_apb_model host_apb_model_i (.clk(clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // xorshift stimulus source
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // expected power after a global command
  function automatic logic [1:0] expPow(input logic [31:0] c,
                                        input logic [1:0] p, input logic on);
    logic [1:0] a;
    a = c[CFG_SCHEME_BIT] ? ~c[CFG_MASK_LSB +: 2] : 2'b11;
    return on ? (p | a) : (p & ~a);
  endfunction
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] i,
                     input logic [31:0] d, output logic [31:0] q);
    host_apb_model_i.xfer(w, i, d);
    q = host_apb_model_i.rdLast;
    chk("pready", 32'h0, {31'h0, host_apb_model_i.toLast});
  endtask
  task automatic printVerdict;
    $display("tests %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    #(40 * 6000);
    badCount++;
    printVerdict();
  end
  // main sequence
  initial begin
    logic [31:0] q;
    logic [31:0] c;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    bus(0, HUB_INDEX, 0, q);
    chk("hub reset", 0, q);
    bus(0, PORT1_INDEX, 0, q);
    chk("port1 reset", 0, q);
    bus(0, PORT2_INDEX, 0, q);
    chk("port2 reset", 0, q);
    bus(0, 8'h17, 0, q);
    chk("port3 err", 1, {31'h0, host_apb_model_i.errLast});
    bus(1, HUB_INDEX, 32'h0000_8000, q);
    bus(1, HUB_INDEX, 32'h0000_0000, q);
    bus(0, HUB_INDEX, 0, q);
    chk("wake set", 32'h0000_8000, q);
    bus(1, HUB_INDEX, 32'h8000_0000, q);
    bus(0, HUB_INDEX, 0, q);
    chk("wake clear", 0, q);
    $display("test reset and wake done");
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      c = (seed & 32'h0006_0000) | k[0];
      bus(1, CONFIG_INDEX, c, q);
      bus(1, PORT1_INDEX, seed[3] ? 32'h100 : 32'h200, q);
      bus(1, PORT2_INDEX, seed[4] ? 32'h100 : 32'h200, q);
      bus(1, HUB_INDEX, k[1] ? 32'h0001_0000 : 32'h0000_0001, q);
      bus(0, HUB_INDEX, 0, q);
      chk("low power bits", 0, q & 32'h0001_0001);
      chk("power", 32'(expPow(c, seed[4:3], k[1])), 32'(portPowerState));
    end
    $display("test power done");
    bus(1, CONFIG_INDEX, 0, q);
    bus(1, IRQ_MASK_INDEX, 0, q);
    overcurrentPin <= 1'b1;
    repeat (6) @(posedge clk);
    bus(0, HUB_INDEX, 0, q);
    chk("oc on", 32'h0002_0002, q & 32'h0002_0002);
    bus(1, HUB_INDEX, 32'h0002_0000, q);
    bus(0, HUB_INDEX, 0, q);
    chk("oc ack", 32'h0000_0002, q & 32'h0002_0002);
    overcurrentPin <= 1'b0;
    repeat (6) @(posedge clk);
    bus(0, HUB_INDEX, 0, q);
    chk("oc off", 32'h0002_0000, q & 32'h0002_0002);
    chk("irq masked", 0, {31'h0, irq});
    bus(1, IRQ_MASK_INDEX, 32'h1, q);
    @(negedge clk);
    chk("irq raised", 1, {31'h0, irq});
    bus(0, IRQ_STATUS_INDEX, 0, q);
    @(posedge clk);
    chk("irq cleared", 0, {31'h0, irq});
    bus(1, CONFIG_INDEX, 32'h2, q);
    overcurrentPin <= 1'b1;
    repeat (6) @(posedge clk);
    bus(0, HUB_INDEX, 0, q);
    chk("oc per port", 0, q & 32'h0000_0002);
    $display("test overcurrent done");
    for (int e = 0; e < 4; e++) begin
      portEvent <= 8'h01 << e;
      @(posedge clk);
      portEvent <= 8'h00;
      bus(0, PORT1_INDEX, 0, q);
      chk("port change", 32'h0002_0000 << e, q & 32'h001F_0000);
      bus(1, PORT1_INDEX, 32'h001F_0000, q);
    end
    bus(1, PORT1_INDEX, 32'h200, q);
    portBusy <= 2'b01;
    bus(1, PORT1_INDEX, 32'h100, q);
    repeat (3) @(posedge clk);
    chk("deferred", 0, {31'h0, portPowerState[0]});
    portBusy <= 2'b00;
    repeat (3) @(posedge clk);
    chk("applied", 1, {31'h0, portPowerState[0]});
    $display("test port word done");
    bus(1, CONTROL_INDEX, 32'h1, q);
    connectPin <= 2'b10;
    repeat (6) @(posedge clk);
    chk("no wake", 32'(SUSPENDED_STATE), 32'(controllerState));
    bus(1, HUB_INDEX, 32'h0000_8000, q);
    connectPin <= 2'b11;
    repeat (6) @(posedge clk);
    chk("resume", 32'(RESUMING_STATE), 32'(controllerState));
    bus(0, IRQ_STATUS_INDEX, 0, q);
    chk("resume irq", 32'h2, q & 32'h2);
    bus(0, PORT1_INDEX, 0, q);
    chk("connect", 32'h0001_0001, q & 32'h0001_0001);
    bus(1, CONTROL_INDEX, 32'h2, q);
    bus(0, CONTROL_INDEX, 0, q);
    chk("resumed", 32'(OPERATIONAL), q);
    $display("test resume done");
    printVerdict();
  end
endmodule
`default_nettype wire
